//--- rtl/tmr_pkg.sv
// Constants shared by the dual timer/counter block
package tmr_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_TL0 = 8'h08;
  localparam logic [7:0] OFS_TH0 = 8'h0C;
  localparam logic [7:0] OFS_TL1 = 8'h10;
  localparam logic [7:0] OFS_TH1 = 8'h14;
  localparam logic [7:0] OFS_OPT = 8'h18;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_CNT = 8'h00;
  // Erased option word: all ones, 12T
  localparam logic [7:0] RST_OPT = 8'hFF;
  // ==========================================================
  // Control register bit positions
  localparam int B_TF1 = 7;
  localparam int B_TR1 = 6;
  localparam int B_TF0 = 5;
  localparam int B_TR0 = 4;
  localparam int B_IE1 = 3;
  localparam int B_IT1 = 2;
  localparam int B_IE0 = 1;
  localparam int B_IT0 = 0;
  // Mode nibble layout: timer1 in [7:4], timer0 in [3:0]
  localparam int B_GATE = 3;
  localparam int B_FSEL = 2;
  localparam int T1_NIB = 4;
  // Option word bit: 0 selects 6T, 1 selects 12T
  localparam int B_SIX_CLK = 0;
  // ==========================================================
  // Counting modes
  localparam logic [1:0] MODE_13 = 2'b00;
  localparam logic [1:0] MODE_16 = 2'b01;
  localparam logic [1:0] MODE_8R = 2'b10;
  localparam logic [1:0] MODE_SPLIT = 2'b11;
  // ==========================================================
  // Machine cycle lengths in oscillator periods
  localparam logic [3:0] MC_LEN_12T = 4'hC;
  localparam logic [3:0] MC_LEN_6T = 4'h6;
endpackage

//--- rtl/pin_sync.sv
// Two-flop synchroniser for the external timer pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pins in, synchronised levels out
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_s
);
  logic [3:0] meta_r;

  // Idle level of all pins is high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= 4'hF;
      pin_s <= 4'hF;
    end else begin
      meta_r <= pin_in;
      pin_s <= meta_r;
    end
  end
endmodule // pin_sync
`default_nettype wire

//--- rtl/mc_divider.sv
// Machine cycle enable generator, 12 or 6 clocks per cycle
`timescale 1ns/1ps
`default_nettype none
module mc_divider
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // 1 selects 12T, 0 selects 6T
  input wire logic twelve_t,
  output logic mc_tick
);
  logic [3:0] cnt_r;
  logic [3:0] last;

  assign last = twelve_t ? (MC_LEN_12T - 4'h1) : (MC_LEN_6T - 4'h1);
  assign mc_tick = (cnt_r >= last);

  // A switch to 6T mid-cycle wraps at once instead of running past the end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 4'h0;
    end else if (mc_tick) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule // mc_divider
`default_nettype wire

//--- rtl/dual_timer.sv
// Dual timer/counter with external interrupt flags on an AHB-Lite slave
//
// Local design decisions: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module dual_timer
  import tmr_pkg::*;
(
  // AHB-Lite
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // External pins
  input wire logic count0_pin,
  input wire logic count1_pin,
  input wire logic ext_int0_pin_n,
  input wire logic ext_int1_pin_n,
  // Interrupt acknowledge from the core, one-cycle pulses
  input wire logic timer0_ack,
  input wire logic timer1_ack,
  input wire logic ext_int0_ack,
  input wire logic ext_int1_ack,
  // Interrupt requests
  output logic timer0_irq,
  output logic timer1_irq,
  output logic ext_int0_irq,
  output logic ext_int1_irq
);
  // ==========================================================
  // Step function: returns {overflow, high, low}
  function automatic logic [16:0] step_f(input logic [1:0] md, input logic [7:0] lo, input logic [7:0] hi);
    logic [13:0] s13;
    logic [16:0] r;
    s13 = 14'h0;
    r = 17'h0;
    case (md)
      // 13-bit: five low bits then eight high bits
      MODE_13: begin
        s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        r = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      end
      MODE_16: begin
        r = {1'b0, hi, lo} + 17'h0_0001;
      end
      MODE_8R: begin
        r = (lo == 8'hFF) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
      end
      default: begin
        r = {(lo == 8'hFF), hi, lo + 8'h01};
      end
    endcase
    return r;
  endfunction

  // ==========================================================
  // Bus slave
  logic [7:0] addr_r;
  logic wr_r;
  logic [7:0] wdat;
  logic [7:0] mode_r;
  logic [7:0] ctrl_r;
  logic [7:0] opt_r;
  logic [7:0] tl0_r;
  logic [7:0] th0_r;
  logic [7:0] tl1_r;
  logic [7:0] th1_r;
  logic [7:0] rd_byte;
  logic wr_mode, wr_ctrl, wr_opt, wr_tl0, wr_th0, wr_tl1, wr_th1;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wdat = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= 8'h00;
      wr_r <= 1'b0;
    end else if (hready) begin
      addr_r <= haddr;
      wr_r <= hsel && htrans[1] && hwrite;
    end
  end

  assign wr_mode = wr_r && (addr_r == OFS_MODE);
  assign wr_ctrl = wr_r && (addr_r == OFS_CTRL);
  assign wr_opt = wr_r && (addr_r == OFS_OPT);
  assign wr_tl0 = wr_r && (addr_r == OFS_TL0);
  assign wr_th0 = wr_r && (addr_r == OFS_TH0);
  assign wr_tl1 = wr_r && (addr_r == OFS_TL1);
  assign wr_th1 = wr_r && (addr_r == OFS_TH1);

  // Read data is a mux of flops in the data phase; unmapped reads give zero
  always_comb begin
    case (addr_r)
      OFS_MODE: rd_byte = mode_r;
      OFS_CTRL: rd_byte = ctrl_r;
      OFS_OPT: rd_byte = opt_r;
      OFS_TL0: rd_byte = tl0_r;
      OFS_TH0: rd_byte = th0_r;
      OFS_TL1: rd_byte = tl1_r;
      OFS_TH1: rd_byte = th1_r;
      default: rd_byte = 8'h00;
    endcase
  end
  assign hrdata = {24'h00_0000, rd_byte};

  // ==========================================================
  // Mode and option registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= RST_MODE;
      opt_r <= RST_OPT;
    end else begin
      if (wr_mode) begin
        mode_r <= wdat;
      end
      if (wr_opt) begin
        opt_r <= wdat;
      end
    end
  end

  // ==========================================================
  // Machine cycle and pin sampling
  logic mc_tick;
  logic [3:0] pin_s;
  logic c0_s, c1_s, i0_s, i1_s;

  mc_divider u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .twelve_t(opt_r[B_SIX_CLK]),
    .mc_tick(mc_tick)
  );

  pin_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in({ext_int1_pin_n, ext_int0_pin_n, count1_pin, count0_pin}),
    .pin_s(pin_s)
  );
  assign c0_s = pin_s[0];
  assign c1_s = pin_s[1];
  assign i0_s = pin_s[2];
  assign i1_s = pin_s[3];

  // sample once per machine cycle
  // Pulses shorter than a machine cycle can be missed; the source must hold each level
  logic [1:0] csamp_r;
  logic evt0, evt1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csamp_r <= 2'b11;
    end else if (mc_tick) begin
      csamp_r <= {c1_s, c0_s};
    end
  end
  assign evt0 = mc_tick && csamp_r[0] && !c0_s;
  assign evt1 = mc_tick && csamp_r[1] && !c1_s;

  // ==========================================================
  // Count enables
  logic [1:0] md0, md1;
  logic en0, en1, inc0, inc1, inc0h;
  logic split0;
  logic [16:0] nx0, nx1;
  logic [8:0] nx0h;
  logic ovf0, ovf1;

  assign md0 = mode_r[1:0];
  assign md1 = mode_r[T1_NIB+1:T1_NIB];
  assign split0 = (md0 == MODE_SPLIT);
  assign en0 = ctrl_r[B_TR0] && (!mode_r[B_GATE] || i0_s);
  assign en1 = ctrl_r[B_TR1] && (!mode_r[T1_NIB+B_GATE] || i1_s);
  assign inc0 = en0 && (mode_r[B_FSEL] ? evt0 : mc_tick);
  assign inc1 = en1 && (md1 != MODE_SPLIT) && (mode_r[T1_NIB+B_FSEL] ? evt1 : mc_tick);
  assign inc0h = split0 && ctrl_r[B_TR1] && mc_tick;

  assign nx0 = step_f(md0, tl0_r, th0_r);
  assign nx1 = step_f(md1, tl1_r, th1_r);
  assign nx0h = {1'b0, th0_r} + 9'h001;
  assign ovf0 = inc0 && nx0[16] && !wr_tl0;
  // split high byte owns timer1 flag
  assign ovf1 = split0 ? (inc0h && nx0h[8] && !wr_th0) : (inc1 && nx1[16] && !wr_tl1);

  // ==========================================================
  // Timer0 count registers; a bus write beats a count in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tl0_r <= RST_CNT;
      th0_r <= RST_CNT;
    end else begin
      if (wr_tl0) begin
        tl0_r <= wdat;
      end else if (inc0) begin
        tl0_r <= nx0[7:0];
      end
      if (wr_th0) begin
        th0_r <= wdat;
      end else if (inc0h) begin
        th0_r <= nx0h[7:0];
      end else if (inc0 && !split0) begin
        th0_r <= nx0[15:8];
      end
    end
  end

  // Timer1 count registers
  // reload leaves high byte as is
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tl1_r <= RST_CNT;
      th1_r <= RST_CNT;
    end else begin
      if (wr_tl1) begin
        tl1_r <= wdat;
      end else if (inc1) begin
        tl1_r <= nx1[7:0];
      end
      if (wr_th1) begin
        th1_r <= wdat;
      end else if (inc1) begin
        th1_r <= nx1[15:8];
      end
    end
  end

  // ==========================================================
  // External interrupt detection
  logic [1:0] iprev_r;
  logic set_ie0, set_ie1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iprev_r <= 2'b11;
    end else begin
      iprev_r <= {i1_s, i0_s};
    end
  end
  // 1 falling edge, 0 low level
  assign set_ie0 = ctrl_r[B_IT0] ? (iprev_r[0] && !i0_s) : !i0_s;
  assign set_ie1 = ctrl_r[B_IT1] ? (iprev_r[1] && !i1_s) : !i1_s;

  // ==========================================================
  // Control register; hardware set wins over any clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= RST_CTRL;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wdat;
      end
      if (timer1_ack) begin
        ctrl_r[B_TF1] <= 1'b0;
      end
      if (timer0_ack) begin
        ctrl_r[B_TF0] <= 1'b0;
      end
      if (ext_int1_ack) begin
        ctrl_r[B_IE1] <= 1'b0;
      end
      if (ext_int0_ack) begin
        ctrl_r[B_IE0] <= 1'b0;
      end
      if (ovf1) begin
        ctrl_r[B_TF1] <= 1'b1;
      end
      if (ovf0) begin
        ctrl_r[B_TF0] <= 1'b1;
      end
      if (set_ie1) begin
        ctrl_r[B_IE1] <= 1'b1;
      end
      if (set_ie0) begin
        ctrl_r[B_IE0] <= 1'b1;
      end
    end
  end

  assign timer0_irq = ctrl_r[B_TF0];
  assign timer1_irq = ctrl_r[B_TF1];
  assign ext_int0_irq = ctrl_r[B_IE0];
  assign ext_int1_irq = ctrl_r[B_IE1];

  // ==========================================================
  // Checks
  logic [15:0] cnt0_w, cnt1_w;
  logic is12;
  assign cnt0_w = {th0_r, tl0_r};
  assign cnt1_w = {th1_r, tl1_r};
  assign is12 = opt_r[B_SIX_CLK];

  sequence s_quiet5;
    !mc_tick [*5];
  endsequence
  property p_tick_min;
    @(posedge hclk) disable iff (!hresetn) mc_tick |=> s_quiet5;
  endproperty
  a_tick_min: assert property (p_tick_min) else $error("machine cycle shorter than six clocks");

  sequence s_hold12;
    mc_tick && is12 ##1 is12 [*6];
  endsequence
  property p_tick_12t;
    @(posedge hclk) disable iff (!hresetn) s_hold12 |-> !mc_tick;
  endproperty
  a_tick_12t: assert property (p_tick_12t) else $error("12T machine cycle ended early");

  property p_timer16;
    @(posedge hclk) disable iff (!hresetn)
      (md0 == MODE_16 && !mode_r[B_FSEL] && en0 && mc_tick && !wr_tl0 && !wr_th0)
      |=> cnt0_w == $past(cnt0_w) + 16'h0001;
  endproperty
  a_timer16: assert property (p_timer16) else $error("timer0 did not advance by one");

  property p_gate_hold;
    @(posedge hclk) disable iff (!hresetn)
      (mode_r[B_GATE] && !i0_s && !split0 && !wr_tl0 && !wr_th0) |=> $stable(cnt0_w);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gated timer0 counted with pin low");

  property p_t1_hold;
    @(posedge hclk) disable iff (!hresetn) (md1 == MODE_SPLIT && !wr_tl1 && !wr_th1) |=> $stable(cnt1_w);
  endproperty
  a_t1_hold: assert property (p_t1_hold) else $error("timer1 moved in mode 11");

  property p_reload;
    @(posedge hclk) disable iff (!hresetn)
      (md0 == MODE_8R && inc0 && tl0_r == 8'hFF && !wr_tl0 && !wr_th0)
      |=> (tl0_r == $past(th0_r)) && ctrl_r[B_TF0];
  endproperty
  a_reload: assert property (p_reload) else $error("auto-reload did not load low byte");

  property p_roll13;
    @(posedge hclk) disable iff (!hresetn)
      (md0 == MODE_13 && inc0 && th0_r == 8'hFF && tl0_r[4:0] == 5'h1F && !wr_tl0 && !wr_th0)
      |=> (tl0_r[4:0] == 5'h00) && (th0_r == 8'h00) && ctrl_r[B_TF0];
  endproperty
  a_roll13: assert property (p_roll13) else $error("13-bit rollover wrong");

  property p_split_flag;
    @(posedge hclk) disable iff (!hresetn)
      (split0 && ctrl_r[B_TR1] && mc_tick && th0_r == 8'hFF && !wr_th0) |=> ctrl_r[B_TF1] && th0_r == 8'h00;
  endproperty
  a_split_flag: assert property (p_split_flag) else $error("split high byte did not set timer1 flag");

  sequence s_fall0;
    iprev_r[0] && !i0_s && ctrl_r[B_IT0];
  endsequence
  property p_edge0;
    @(posedge hclk) disable iff (!hresetn) s_fall0 |=> ctrl_r[B_IE0] ##1 (ctrl_r[B_IE0] || $past(ext_int0_ack) || $past(wr_ctrl));
  endproperty
  a_edge0: assert property (p_edge0) else $error("edge flag lost after falling edge");

  property p_count_evt;
    @(posedge hclk) disable iff (!hresetn)
      (mode_r[B_FSEL] && en0 && md0 == MODE_16 && !evt0 && !wr_tl0 && !wr_th0) |=> $stable(cnt0_w);
  endproperty
  a_count_evt: assert property (p_count_evt) else $error("counter moved without a 1-to-0 event");
endmodule // dual_timer
`default_nettype wire

//--- dv/pin_model.sv
// Partner model of the external count and interrupt pins
`timescale 1ns/1ps
`default_nettype none
module pin_model #(
  parameter int HOLD = 30
) (
  // Clock
  input wire logic hclk,
  // Pins towards the timer block
  output logic [1:0] count_pin,
  output logic [1:0] int_pin_n
);
  // ==========================================
  // Pin drivers
  // Pins idle high, as on a port with pull-ups
  initial begin
    count_pin = 2'h3;
    int_pin_n = 2'h3;
  end
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge hclk);
      count_pin[ch] <= 1'h0;
      repeat (HOLD) @(posedge hclk);
      count_pin[ch] <= 1'h1;
      repeat (HOLD) @(posedge hclk);
    end
  endtask
  task automatic set_int(input int ch, input logic v);
    @(posedge hclk);
    int_pin_n[ch] <= v;
    repeat (HOLD) @(posedge hclk);
  endtask
endmodule // pin_model
`default_nettype wire

//--- dv/test_dual_timer_counter_t0_t1.sv
// Self-checking bench for the dual timer/counter block
`timescale 1ns/1ps
`default_nettype none
module test_dual_timer_counter_t0_t1
  import tmr_pkg::*;
;
  localparam int LIMIT = 20000;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic [31:0] rd_q;
  logic hreadyout;
  logic hresp;
  logic [3:0] ack = 4'h0;
  logic [3:0] irq;
  logic [1:0] cnt_pin;
  logic [1:0] int_n;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  always #5 hclk = ~hclk;
  dual_timer i_dual_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .count0_pin(cnt_pin[0]), .count1_pin(cnt_pin[1]),
    .ext_int0_pin_n(int_n[0]), .ext_int1_pin_n(int_n[1]), .timer0_ack(ack[0]), .timer1_ack(ack[1]),
    .ext_int0_ack(ack[2]), .ext_int1_ack(ack[3]), .timer0_irq(irq[0]), .timer1_irq(irq[1]),
    .ext_int0_irq(irq[2]), .ext_int1_irq(irq[3]));
  pin_model i_pin_model (.hclk(hclk), .count_pin(cnt_pin), .int_pin_n(int_n));
  // Read data as it stood at the edge, free of update races
  always @(posedge hclk) rd_q <= hrdata;
  always @(posedge hclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      close_out();
    end
  end
  // ==========================================
  // Shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_rdy();
    do @(posedge hclk); while (hreadyout !== 1'h1);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    #1;
    q = rd_q;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'h1, a, {24'h00_0000, d}, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'h0, a, 32'h0000_0000, q);
    check(nm, q, {24'h00_0000, e});
  endtask
  task automatic wait_irq(input int i, input int lim);
    int n = 0;
    while (irq[i] !== 1'h1 && n < lim) begin
      @(posedge hclk);
      n++;
    end
  endtask
  task automatic pulse_ack(input int i);
    @(posedge hclk);
    ack[i] <= 1'h1;
    @(posedge hclk);
    ack[i] <= 1'h0;
    repeat (2) @(posedge hclk);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    rd("mode", OFS_MODE, RST_MODE);
    rd("ctrl", OFS_CTRL, RST_CTRL);
    rd("option", OFS_OPT, RST_OPT);
    rd("unmapped", 8'h40, 8'h00);
    check("resp", hresp, 1'h0);
    check("ready", hreadyout, 1'h1);
    $display("test reset done");
  endtask
  task automatic t_ovf(input string nm, input logic [7:0] mode, tla, tha, tl, th, run, input int i,
                       input logic [7:0] etl, eth);
    logic [7:0] flag;
    flag = (i == 0) ? 8'h20 : 8'h80;
    wr(tla, tl);
    wr(tha, th);
    wr(OFS_MODE, mode);
    wr(OFS_CTRL, run);
    wait_irq(i, 40);
    // Stop at once, keeping the flag, before the next tick
    wr(OFS_CTRL, flag);
    check(nm, irq[i], 1'h1);
    rd(nm, tla, etl);
    rd(nm, tha, eth);
    rd(nm, OFS_CTRL, flag);
    pulse_ack(i);
    check(nm, irq[i], 1'h0);
    $display("test %s done", nm);
  endtask
  task automatic t_hold();
    wr(OFS_TL1, 8'h12);
    wr(OFS_MODE, 8'h30);
    wr(OFS_CTRL, 8'h40);
    repeat (60) @(posedge hclk);
    rd("t1 hold", OFS_TL1, 8'h12);
    wr(OFS_CTRL, 8'h00);
    $display("test hold done");
  endtask
  task automatic t_count();
    wr(OFS_TL0, 8'h00);
    wr(OFS_TH0, 8'h00);
    wr(OFS_MODE, 8'h05);
    wr(OFS_CTRL, 8'h10);
    i_pin_model.pulse(0, 5);
    rd("count", OFS_TL0, 8'h05);
    wr(OFS_MODE, 8'h0D);
    i_pin_model.set_int(0, 1'h0);
    i_pin_model.pulse(0, 3);
    rd("gate shut", OFS_TL0, 8'h05);
    i_pin_model.set_int(0, 1'h1);
    i_pin_model.pulse(0, 2);
    rd("gate open", OFS_TL0, 8'h07);
    wr(OFS_CTRL, 8'h00);
    $display("test count done");
  endtask
  task automatic t_ext();
    wr(OFS_CTRL, 8'h05);
    for (int i = 0; i < 2; i++) begin
      i_pin_model.set_int(i, 1'h0);
      check("edge set", irq[2 + i], 1'h1);
      i_pin_model.set_int(i, 1'h1);
      pulse_ack(2 + i);
      check("edge ack", irq[2 + i], 1'h0);
    end
    rd("edge ctrl", OFS_CTRL, 8'h05);
    wr(OFS_CTRL, 8'h00);
    i_pin_model.set_int(1, 1'h0);
    pulse_ack(3);
    check("level low", irq[3], 1'h1);
    i_pin_model.set_int(1, 1'h1);
    pulse_ack(3);
    check("level high", irq[3], 1'h0);
    $display("test ext done");
  endtask
  task automatic t_rate(input string nm, input logic [7:0] opt, input logic [31:0] lo, hi);
    logic [31:0] q;
    wr(OFS_OPT, opt);
    wr(OFS_MODE, 8'h01);
    wr(OFS_TL0, 8'h00);
    wr(OFS_TH0, 8'h00);
    wr(OFS_CTRL, 8'h10);
    repeat (240) @(posedge hclk);
    wr(OFS_CTRL, 8'h00);
    bus(1'h0, OFS_TL0, 32'h0000_0000, q);
    // Divider phase is unknown, so one tick either way at 12T; 6T allows one below and two above
    check(nm, q >= lo && q <= hi, 1'h1);
    $display("test %s done", nm);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    hsel <= 1'h1;
    t_reset();
    t_ovf("m13", 8'h00, OFS_TL0, OFS_TH0, 8'hFF, 8'hFF, 8'h10, 0, 8'hE0, 8'h00);
    t_ovf("m16", 8'h01, OFS_TL0, OFS_TH0, 8'hFF, 8'hFF, 8'h10, 0, 8'h00, 8'h00);
    t_ovf("m8r0", 8'h02, OFS_TL0, OFS_TH0, 8'hFF, 8'h80, 8'h10, 0, 8'h80, 8'h80);
    t_ovf("m8r", 8'h20, OFS_TL1, OFS_TH1, 8'hFF, 8'h80, 8'h40, 1, 8'h80, 8'h80);
    t_ovf("split", 8'h03, OFS_TL0, OFS_TH0, 8'h00, 8'hFF, 8'h40, 1, 8'h00, 8'h00);
    t_hold();
    t_count();
    t_ext();
    t_rate("rate 12T", 8'hFF, 32'h0000_0013, 32'h0000_0015);
    t_rate("rate 6T", 8'hFE, 32'h0000_0027, 32'h0000_002A);
    close_out();
  end
endmodule // test_dual_timer_counter_t0_t1
`default_nettype wire
